// >>> verilog/limit_irq_pkg.sv
// package: register map, status bit layout and persistence constants of the threshold interrupt logic
package limit_irq_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LOW_THRESHOLD_HIGH_BYTE = 8'h8A;
  localparam logic [7:0] ADDR_LOW_THRESHOLD_LOW_BYTE = 8'h8B;
  localparam logic [7:0] ADDR_HIGH_THRESHOLD_HIGH_BYTE = 8'h8C;
  localparam logic [7:0] ADDR_HIGH_THRESHOLD_LOW_BYTE = 8'h8D;
  localparam logic [7:0] ADDR_INTERRUPT_CAUSE_FLAGS = 8'h8E;

  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int BIT_ABOVE_LIMIT = 0;
  localparam int BIT_BELOW_LIMIT = 1;
  localparam int BIT_AMBIENT_READY = 2;
  localparam int BIT_PROX_READY = 3;
  localparam int FLAG_COUNT = 4;

  // ----------------------------------------------------------------
  // reset values and unmapped read data
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_THRESHOLD_BYTE = 8'h00;
  localparam logic [7:0] RESET_READ_DATA = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_DATA = 8'h00;

  // ----------------------------------------------------------------
  // persistence counting
  // ----------------------------------------------------------------
  localparam int PERSIST_CODE_WIDTH = 3;
  localparam int PERSIST_COUNT_WIDTH = 8;
  localparam logic [7:0] PERSIST_ONE = 8'h01;
  localparam logic [7:0] PERSIST_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  typedef enum logic {
    SOURCE_PROXIMITY,
    SOURCE_AMBIENT
  } limit_source_t;

endpackage

// >>> verilog/cause_flag.sv
// module: one sticky status flag, set by hardware, cleared by writing one
`timescale 1ns/1ns
module cause_flag (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic set_i,
  input wire logic clear_i,
  output logic flag_o
);

  logic flag;
  logic next_flag;

  // ----------------------------------------------------------------
  // set wins over a clear in the same cycle so no event is lost
  // ----------------------------------------------------------------
  always_comb begin
    next_flag = set_i | (flag & ~clear_i);
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  assign flag_o = flag;

endmodule

// >>> verilog/persist_counter.sv
// module: consecutive-measurement counter that fires once a crossing has persisted long enough
`timescale 1ns/1ns
module persist_counter #(
  parameter int COUNT_WIDTH = limit_irq_pkg::PERSIST_COUNT_WIDTH
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic restart_i,
  input wire logic sample_i,
  input wire logic beyond_i,
  input wire logic [COUNT_WIDTH-1:0] needed_i,
  output logic fire_o
);

  logic [COUNT_WIDTH-1:0] count;
  logic [COUNT_WIDTH-1:0] next_count;
  logic next_fire;

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  // counter saturates at the needed figure: one event per excursion,
  // a long excursion does not keep re-firing
  always_comb begin
    next_count = count;
    next_fire = 1'b0;
    if (restart_i) begin
      next_count = '0;
    end else if (sample_i) begin
      if (!beyond_i) begin
        next_count = '0;
      end else if (count < needed_i) begin
        next_count = count + COUNT_WIDTH'(1);
        next_fire = ((count + COUNT_WIDTH'(1)) == needed_i);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign fire_o = next_fire;

endmodule

// >>> verilog/threshold_interrupt_logic.sv
// module: threshold and data-ready interrupt logic with its byte registers and open-drain pad
`timescale 1ns/1ns

module threshold_interrupt_logic #(
  parameter int RESULT_WIDTH = 16
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // register port from the serial front end
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // interrupt control bits
  input wire logic limit_irq_enable_i,
  input wire logic limit_source_select_i,
  input wire logic [limit_irq_pkg::PERSIST_CODE_WIDTH-1:0] persist_code_i,
  input wire logic prox_ready_enable_i,
  input wire logic ambient_ready_enable_i,
  // measurement results
  input wire logic [RESULT_WIDTH-1:0] prox_result_i,
  input wire logic prox_done_i,
  input wire logic [RESULT_WIDTH-1:0] ambient_result_i,
  input wire logic ambient_done_i,
  // open-drain interrupt pad and status flags
  output logic int_pad_o,
  output logic int_pad_oe_n_o,
  output logic [limit_irq_pkg::FLAG_COUNT-1:0] cause_flags_o
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // one decode feeds both paths, so the read and write maps cannot drift apart
  logic hit_low_high_byte;
  logic hit_low_low_byte;
  logic hit_high_high_byte;
  logic hit_high_low_byte;
  logic hit_cause_flags;

  always_comb begin
    hit_low_high_byte = 1'b0;
    hit_low_low_byte = 1'b0;
    hit_high_high_byte = 1'b0;
    hit_high_low_byte = 1'b0;
    hit_cause_flags = 1'b0;
    if (reg_addr_i == limit_irq_pkg::ADDR_LOW_THRESHOLD_HIGH_BYTE) begin
      hit_low_high_byte = 1'b1;
    end else if (reg_addr_i == limit_irq_pkg::ADDR_LOW_THRESHOLD_LOW_BYTE) begin
      hit_low_low_byte = 1'b1;
    end else if (reg_addr_i == limit_irq_pkg::ADDR_HIGH_THRESHOLD_HIGH_BYTE) begin
      hit_high_high_byte = 1'b1;
    end else if (reg_addr_i == limit_irq_pkg::ADDR_HIGH_THRESHOLD_LOW_BYTE) begin
      hit_high_low_byte = 1'b1;
    end else if (reg_addr_i == limit_irq_pkg::ADDR_INTERRUPT_CAUSE_FLAGS) begin
      hit_cause_flags = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // write strobes
  // ----------------------------------------------------------------
  // a read in the same cycle is taken too and sees the old value
  logic wr_low_high_byte;
  logic wr_low_low_byte;
  logic wr_high_high_byte;
  logic wr_high_low_byte;
  logic wr_cause_flags;

  always_comb begin
    wr_low_high_byte = reg_wr_i & hit_low_high_byte;
    wr_low_low_byte = reg_wr_i & hit_low_low_byte;
    wr_high_high_byte = reg_wr_i & hit_high_high_byte;
    wr_high_low_byte = reg_wr_i & hit_high_low_byte;
    wr_cause_flags = reg_wr_i & hit_cause_flags;
  end

  // ----------------------------------------------------------------
  // threshold registers
  // ----------------------------------------------------------------
  // bytes land one at a time: between two byte writes the compare sees a mixed value
  logic [7:0] low_threshold_high_byte;
  logic [7:0] low_threshold_low_byte;
  logic [7:0] high_threshold_high_byte;
  logic [7:0] high_threshold_low_byte;
  logic [7:0] next_low_threshold_high_byte;
  logic [7:0] next_low_threshold_low_byte;
  logic [7:0] next_high_threshold_high_byte;
  logic [7:0] next_high_threshold_low_byte;

  always_comb begin
    next_low_threshold_high_byte = low_threshold_high_byte;
    next_low_threshold_low_byte = low_threshold_low_byte;
    next_high_threshold_high_byte = high_threshold_high_byte;
    next_high_threshold_low_byte = high_threshold_low_byte;
    if (wr_low_high_byte) begin
      next_low_threshold_high_byte = reg_wdata_i;
    end
    if (wr_low_low_byte) begin
      next_low_threshold_low_byte = reg_wdata_i;
    end
    if (wr_high_high_byte) begin
      next_high_threshold_high_byte = reg_wdata_i;
    end
    if (wr_high_low_byte) begin
      next_high_threshold_low_byte = reg_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      low_threshold_high_byte <= limit_irq_pkg::RESET_THRESHOLD_BYTE;
      low_threshold_low_byte <= limit_irq_pkg::RESET_THRESHOLD_BYTE;
      high_threshold_high_byte <= limit_irq_pkg::RESET_THRESHOLD_BYTE;
      high_threshold_low_byte <= limit_irq_pkg::RESET_THRESHOLD_BYTE;
    end else begin
      low_threshold_high_byte <= next_low_threshold_high_byte;
      low_threshold_low_byte <= next_low_threshold_low_byte;
      high_threshold_high_byte <= next_high_threshold_high_byte;
      high_threshold_low_byte <= next_high_threshold_low_byte;
    end
  end

  logic [15:0] low_threshold;
  logic [15:0] high_threshold;
  assign low_threshold = {low_threshold_high_byte, low_threshold_low_byte};
  assign high_threshold = {high_threshold_high_byte, high_threshold_low_byte};

  // ----------------------------------------------------------------
  // source selection and comparison
  // ----------------------------------------------------------------
  limit_irq_pkg::limit_source_t source;
  logic [RESULT_WIDTH-1:0] monitored_result;
  logic monitored_done;
  logic is_below;
  logic is_above;

  always_comb begin
    source = limit_source_select_i ? limit_irq_pkg::SOURCE_AMBIENT : limit_irq_pkg::SOURCE_PROXIMITY;
    case (source)
      limit_irq_pkg::SOURCE_AMBIENT: begin
        monitored_result = ambient_result_i;
        monitored_done = ambient_done_i;
      end
      default: begin
        monitored_result = prox_result_i;
        monitored_done = prox_done_i;
      end
    endcase
    // unsigned compare; equality is not a crossing
    is_below = (monitored_result < low_threshold);
    is_above = (monitored_result > high_threshold);
  end

  // ----------------------------------------------------------------
  // persistence
  // ----------------------------------------------------------------
  logic [limit_irq_pkg::PERSIST_COUNT_WIDTH-1:0] persist_needed;
  logic source_prev;
  logic next_source_prev;
  logic persist_restart;
  logic below_fire;
  logic above_fire;

  // a source switch or a disabled threshold function restarts the counts,
  // so a half-finished run on one source never completes on the other
  always_comb begin
    persist_needed = limit_irq_pkg::PERSIST_ONE << persist_code_i;
    next_source_prev = limit_source_select_i;
    persist_restart = (source_prev != limit_source_select_i) | ~limit_irq_enable_i;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      source_prev <= 1'b0;
    end else begin
      source_prev <= next_source_prev;
    end
  end

  persist_counter #(
    .COUNT_WIDTH(limit_irq_pkg::PERSIST_COUNT_WIDTH)
  ) below_counter (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .restart_i(persist_restart),
    .sample_i(monitored_done),
    .beyond_i(is_below),
    .needed_i(persist_needed),
    .fire_o(below_fire)
  );

  persist_counter #(
    .COUNT_WIDTH(limit_irq_pkg::PERSIST_COUNT_WIDTH)
  ) above_counter (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .restart_i(persist_restart),
    .sample_i(monitored_done),
    .beyond_i(is_above),
    .needed_i(persist_needed),
    .fire_o(above_fire)
  );

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  logic [limit_irq_pkg::FLAG_COUNT-1:0] flag_set;
  logic [limit_irq_pkg::FLAG_COUNT-1:0] flag_clear;
  logic [limit_irq_pkg::FLAG_COUNT-1:0] flags;
  logic status_write;

  always_comb begin
    status_write = wr_cause_flags;
    flag_set = '0;
    flag_set[limit_irq_pkg::BIT_BELOW_LIMIT] = limit_irq_enable_i & below_fire;
    flag_set[limit_irq_pkg::BIT_ABOVE_LIMIT] = limit_irq_enable_i & above_fire;
    flag_set[limit_irq_pkg::BIT_PROX_READY] = prox_ready_enable_i & prox_done_i;
    flag_set[limit_irq_pkg::BIT_AMBIENT_READY] = ambient_ready_enable_i & ambient_done_i;
    flag_clear = status_write ? reg_wdata_i[limit_irq_pkg::FLAG_COUNT-1:0] : '0;
  end

  genvar g;
  generate
    for (g = 0; g < limit_irq_pkg::FLAG_COUNT; g++) begin : gen_flags
      cause_flag flag_bit (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .set_i(flag_set[g]),
        .clear_i(flag_clear[g]),
        .flag_o(flags[g])
      );
    end
  endgenerate

  assign cause_flags_o = flags;

  // ----------------------------------------------------------------
  // interrupt pad
  // ----------------------------------------------------------------
  // pad follows the flag flip-flops combinationally, changing on the same edge as a set or clear
  logic pad_active;
  assign pad_active = |flags;
  assign int_pad_o = 1'b0;
  assign int_pad_oe_n_o = ~pad_active;

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  // read data holds between reads, so a late pickup still sees it
  logic [7:0] read_data;
  logic [7:0] next_read_data;
  logic read_valid;
  logic next_read_valid;

  always_comb begin
    next_read_data = read_data;
    next_read_valid = reg_rd_i;
    if (reg_rd_i) begin
      if (hit_low_high_byte) begin
        next_read_data = low_threshold_high_byte;
      end else if (hit_low_low_byte) begin
        next_read_data = low_threshold_low_byte;
      end else if (hit_high_high_byte) begin
        next_read_data = high_threshold_high_byte;
      end else if (hit_high_low_byte) begin
        next_read_data = high_threshold_low_byte;
      end else if (hit_cause_flags) begin
        next_read_data = {4'h0, flags};
      end else begin
        next_read_data = limit_irq_pkg::UNMAPPED_READ_DATA;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      read_data <= limit_irq_pkg::RESET_READ_DATA;
      read_valid <= 1'b0;
    end else begin
      read_data <= next_read_data;
      read_valid <= next_read_valid;
    end
  end

  assign reg_rdata_o = read_data;
  assign reg_rvalid_o = read_valid;

endmodule

// >>> testbench/til_chk.sv
// checker: port-level assertions of the threshold interrupt logic
`timescale 1ns/1ns
module til_chk (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic limit_irq_enable_i,
  input wire logic limit_source_select_i,
  input wire logic prox_ready_enable_i,
  input wire logic ambient_ready_enable_i,
  input wire logic prox_done_i,
  input wire logic ambient_done_i,
  input wire logic int_pad_o,
  input wire logic int_pad_oe_n_o,
  input wire logic [3:0] cause_flags_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic clr;
  logic sel_done;
  assign clr = reg_wr_i && reg_addr_i == limit_irq_pkg::ADDR_INTERRUPT_CAUSE_FLAGS;
  assign sel_done = limit_source_select_i ? ambient_done_i : prox_done_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_read_answered: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read strobe not answered");
  a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("read valid without read");
  a_status_read: assert property (reg_rd_i && reg_addr_i == 8'h8E |=> reg_rdata_o == {4'h0, $past(cause_flags_o)})
    else $error("status read differs from flags");
  a_pad_follows: assert property ((int_pad_oe_n_o == !(|cause_flags_o)) && !int_pad_o)
    else $error("pad drive differs from flags");
  a_flag_sticky: assert property ((($past(cause_flags_o) & ~cause_flags_o) & ~({4{$past(clr)}} & $past(reg_wdata_i[3:0]))) == 4'h0)
    else $error("flag fell without clear");
  a_clear_works: assert property (clr && reg_wdata_i[3] && !(prox_done_i && prox_ready_enable_i) |=> !cause_flags_o[3])
    else $error("write one did not clear");
  a_prox_ready: assert property (prox_done_i && prox_ready_enable_i |=> cause_flags_o[3])
    else $error("proximity ready not set");
  a_amb_ready: assert property (ambient_done_i && ambient_ready_enable_i |=> cause_flags_o[2])
    else $error("ambient ready not set");
  a_ready_cause: assert property ($rose(cause_flags_o[3]) |-> $past(prox_done_i && prox_ready_enable_i))
    else $error("ready flag without cause");
  a_limit_cause: assert property (|(~$past(cause_flags_o[1:0]) & cause_flags_o[1:0]) |-> $past(limit_irq_enable_i && sel_done))
    else $error("limit flag without enabled sample");
  c_below: cover property ($rose(cause_flags_o[1]));
  c_above: cover property ($rose(cause_flags_o[0]));
  c_clear: cover property (clr && |cause_flags_o ##1 !(|cause_flags_o));
endmodule
bind threshold_interrupt_logic til_chk chk_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .limit_irq_enable_i(limit_irq_enable_i), .limit_source_select_i(limit_source_select_i),
  .prox_ready_enable_i(prox_ready_enable_i), .ambient_ready_enable_i(ambient_ready_enable_i),
  .prox_done_i(prox_done_i), .ambient_done_i(ambient_done_i), .int_pad_o(int_pad_o),
  .int_pad_oe_n_o(int_pad_oe_n_o), .cause_flags_o(cause_flags_o));

// >>> testbench/reg_host.sv
// partner: register host on the byte strobe port
`timescale 1ns/1ns
module reg_host (
  input wire logic mclk_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_rd_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'h0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'h0;
  end
  // idle lines show the inverse so stale values never look valid
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'h1;
    @(posedge mclk_i);
    reg_wr_o <= 1'h0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  task automatic get(input logic [7:0] a);
    @(posedge mclk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'h1;
    @(posedge mclk_i);
    reg_rd_o <= 1'h0;
    reg_addr_o <= ~a;
  endtask
endmodule

// >>> testbench/threshold_interrupt_logic_tb_top.sv
// testbench: model-based check of the threshold interrupt logic
`timescale 1ns/1ns
module threshold_interrupt_logic_tb_top;
  logic mclk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, rvalid, pad, oe_n;
  logic ten = 1'h0, sel = 1'h0, pen = 1'h0, aen = 1'h0, pdone = 1'h0, adone = 1'h0;
  logic [2:0] code = 3'h0;
  logic [15:0] pres = 16'h0000, ares = 16'h0000;
  logic [3:0] flags;
  logic [7:0] thr_b [4];
  int bad_count = 0;
  int n_tests = 0;
  int seed = 32;
  int m_low, m_high, m_flags = 0, c_lo = 0, c_hi = 0, v;
  always #20 mclk_i = ~mclk_i;
  reg_host host_u (.mclk_i(mclk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata),
    .reg_rd_o(reg_rd));
  threshold_interrupt_logic dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr),
    .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .reg_rvalid_o(rvalid),
    .limit_irq_enable_i(ten), .limit_source_select_i(sel), .persist_code_i(code), .prox_ready_enable_i(pen),
    .ambient_ready_enable_i(aen), .prox_result_i(pres), .prox_done_i(pdone), .ambient_result_i(ares),
    .ambient_done_i(adone), .int_pad_o(pad), .int_pad_oe_n_o(oe_n), .cause_flags_o(flags));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host_u.get(a);
    #1;
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk("rdata", e, reg_rdata);
  endtask
  task automatic see;
    @(posedge mclk_i);
    #1;
    chk("flags", 8'(m_flags), {4'h0, flags});
    chk("pad", {7'h00, m_flags == 0}, {6'h00, pad, oe_n});
  endtask
  task automatic clr(input logic [7:0] w);
    host_u.put(8'h8E, w);
    m_flags &= ~int'(w[3:0]);
    see();
  endtask
  task automatic thrs(input int lo, input int hi);
    host_u.put(8'h8A, 8'(lo >> 8));
    host_u.put(8'h8B, 8'(lo));
    host_u.put(8'h8C, 8'(hi >> 8));
    host_u.put(8'h8D, 8'(hi));
    m_low = lo;
    m_high = hi;
  endtask
  task automatic ctl(input logic t, input logic s, input logic p, input logic a, input logic [2:0] c);
    if (!t || s !== sel) begin
      c_lo = 0;
      c_hi = 0;
    end
    @(posedge mclk_i);
    ten <= t;
    sel <= s;
    pen <= p;
    aen <= a;
    code <= c;
    repeat (2) @(posedge mclk_i);
  endtask
  // saturating count: a long excursion fires only once
  task automatic smp(input int src, input int val);
    @(posedge mclk_i);
    pdone <= (src == 0);
    adone <= (src == 1);
    pres <= 16'(val);
    ares <= 16'(val);
    @(posedge mclk_i);
    pdone <= 1'h0;
    adone <= 1'h0;
    pres <= ~16'(val);
    ares <= ~16'(val);
    if (src == 0 && pen) m_flags |= 8;
    if (src == 1 && aen) m_flags |= 4;
    if (ten && src == sel) begin
      if (val >= m_low) c_lo = 0;
      else if (c_lo < (1 << code)) begin
        c_lo++;
        if (c_lo == (1 << code)) m_flags |= 2;
      end
      if (val <= m_high) c_hi = 0;
      else if (c_hi < (1 << code)) begin
        c_hi++;
        if (c_hi == (1 << code)) m_flags |= 1;
      end
    end
    see();
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'h0;
    for (int i = 0; i < 6; i++) rd(8'h8A + 8'(i), 8'h00);
    for (int i = 0; i < 4; i++) begin
      thr_b[i] = 8'($random(seed));
      host_u.put(8'h8A + 8'(i), thr_b[i]);
    end
    host_u.put(8'h8F, 8'hFF);
    for (int i = 0; i < 6; i++) rd(8'h8A + 8'(i), i < 4 ? thr_b[i] : 8'h00);
    thrs(16'h1000, 16'hF000);
    for (int c = 0; c < 8; c++) begin
      ctl(1'h0, 1'h0, 1'h0, 1'h0, 3'(c));
      ctl(1'h1, 1'h0, 1'h0, 1'h0, 3'(c));
      for (int k = 0; k <= (1 << c); k++) smp(0, 16'h0FFF);
      clr(8'hF0);
      clr(8'h0F);
      smp(0, 16'h0000);
    end
    for (int b = 0; b < 16; b++) begin
      v = $random(seed) & 16'h003F;
      thrs(v, v + ($random(seed) & 16'h003F));
      ctl(1'($random(seed)), 1'($random(seed)), 1'($random(seed)), 1'($random(seed)), 3'($random(seed) & 3));
      for (int k = 0; k < 24; k++) begin
        smp($random(seed) & 1, $random(seed) & 16'h007F);
        if (k % 8 == 7) clr(8'($random(seed)));
      end
      rd(8'h8E, 8'(m_flags));
    end
    // mid-run reset: flags, pad and thresholds must all return to idle
    @(posedge mclk_i);
    sys_rst_i <= 1'h1;
    repeat (4) @(posedge mclk_i);
    sys_rst_i <= 1'h0;
    m_flags = 0;
    c_lo = 0;
    c_hi = 0;
    m_low = 0;
    m_high = 0;
    see();
    for (int i = 0; i < 5; i++) rd(8'h8A + 8'(i), 8'h00);
    conclude;
  end
  initial begin
    repeat (100000) @(posedge mclk_i);
    bad_count++;
    conclude;
  end
endmodule
